// file: hw/tzc_pkg.sv
/*
 * constants, register map and field positions of the 16-bit timer zero
 * counter with prescaler, edge select and overflow interrupt flag.
 * assumes a plain byte-wide register port and one 100 MHz system clock.
 */
package tzc_pkg;
   // register offsets
   localparam logic [7:0] OFS_CONTROL   = 8'h05;
   localparam logic [7:0] OFS_CPU_STAT  = 8'h06;
   localparam logic [7:0] OFS_INT_STAT  = 8'h07;
   localparam logic [7:0] OFS_CNT_LOW   = 8'h0B;
   localparam logic [7:0] OFS_CNT_HIGH  = 8'h0C;
   localparam logic [7:0] OFS_INT_MASK  = 8'h0D;
   // control register fields
   localparam int BIT_INT_EDGE  = 7;
   localparam int BIT_EDGE_SEL  = 6;
   localparam int BIT_SRC_SEL   = 5;
   localparam int PS_MSB        = 4;
   localparam int PS_LSB        = 1;
   // interrupt status, enable and mask fields
   localparam int BIT_OVF_FLAG  = 5;
   localparam int BIT_OVF_EN    = 1;
   // reset values
   localparam logic [7:0]  RST_CONTROL = 8'h00;
   localparam logic [7:0]  RST_INT     = 8'h00;
   localparam logic [15:0] RST_COUNT   = 16'h0000;
   localparam logic        RST_MASK    = 1'b1;
   localparam logic        RST_SAMP    = 1'b1; // sampler idles high
   localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;
   // prescale: log2 of ratio, codes above the top code divide by 256
   localparam logic [3:0] PS_LOG_MAX  = 4'h8;
   // instruction cycle phases, one oscillator period each
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   // pin edge to counter change window, oscillator periods
   localparam int TOSC_NS     = 10;
   localparam int DLY_MIN_OSC = 3;
   localparam int DLY_MAX_OSC = 7;
endpackage

// file: hw/tzc_timer.sv
/*
 * timer zero: prescaler, pin synchroniser, twice-per-cycle sampler,
 * 16-bit up counter, overflow flag with enable and mask, register port.
 * assumes the core pulses vector_ack_in when it vectors to this timer,
 * and a master that never raises both strobes in one cycle.
 */
`timescale 1ns/100ps
module tzc_timer (
   input  wire logic       sys_clk_in,   // oscillator clock, 100 MHz
   input  wire logic       srst_in,      // sync reset, active high
   input  wire logic [7:0] addr_in,      // register address
   input  wire logic [7:0] wdata_in,     // write data
   input  wire logic       wr_in,        // write strobe
   input  wire logic       rd_in,        // read strobe
   input  wire logic       count_pin_in, // external count pin, async
   input  wire logic       vector_ack_in,// core vectors to timer
   output logic      [7:0] rdata_out,    // read data, cycle after rd
   output logic            irq_out       // level interrupt request
);

   typedef struct packed {
      logic        pin_s1;     // first sync flop
      logic        pin_s2;     // second sync flop
      logic        pin_d;      // delayed synced pin for edge
      logic [1:0]  phase;      // instruction cycle phase
      logic [7:0]  pre_cnt;    // prescaler counter
      logic        samp;       // last prescaler output sample
      logic [15:0] cnt;        // main counter
      logic        int_edge;   // stored, unused here
      logic        edge_sel;   // count edge select
      logic        src_sel;    // count source select
      logic [3:0]  ps;         // prescale select
      logic        ovf_flag;   // counter overflow flag
      logic        ovf_en;     // counter overflow enable
      logic        ovf_mask;   // extra mask
      logic [7:0]  rdata;      // read data
      logic        irq;        // interrupt request
   } tzc_state_s;

   tzc_state_s st_reg;
   tzc_state_s st_next;

   logic       tick_int;     // one per instruction cycle
   logic       samp_en;      // sampling phases
   logic [3:0] ps_log;       // log2 of ratio
   logic [2:0] ps_log_m1;    // bit index of prescaler output
   logic [7:0] ps_mask;      // prescaler wrap mask
   logic       pin_eff;      // pin after edge select
   logic       pin_eff_d;    // delayed pin after edge select
   logic       pre_evt;      // prescaler input event
   logic       ps_out;       // prescaler output level
   logic       inc;          // counter increment pulse
   logic       wr_low;       // write to low byte
   logic       wr_high;      // write to high byte
   logic       wr_int;       // write to interrupt register
   logic       ovf_set;      // wrap event

   // phase decode and prescaler selection
   always_comb begin
      tick_int  = (st_reg.phase == tzc_pkg::PH_Q4);
      samp_en   = (st_reg.phase == tzc_pkg::PH_Q2) ||
                  (st_reg.phase == tzc_pkg::PH_Q4);
      ps_log    = (st_reg.ps > tzc_pkg::PS_LOG_MAX) ?
                  tzc_pkg::PS_LOG_MAX : st_reg.ps;
      ps_log_m1 = 3'(ps_log - 4'h1);
      ps_mask   = 8'((9'h001 << ps_log) - 9'h001);
      pin_eff   = st_reg.edge_sel ? st_reg.pin_s2 : ~st_reg.pin_s2;
      pin_eff_d = st_reg.edge_sel ? st_reg.pin_d : ~st_reg.pin_d;
   end

   // in pin mode the prescaler, or at 1:1 the synced pin, feeds the sampler; internal mode counts prescaler wraps directly
   always_comb begin
      if (st_reg.src_sel) begin
         pre_evt = tick_int;
      end else begin
         pre_evt = pin_eff & ~pin_eff_d;
      end
      if (ps_log == 4'h0) begin
         ps_out = pin_eff;
      end else begin
         ps_out = st_reg.pre_cnt[ps_log_m1];
      end
      if (st_reg.src_sel) begin
         inc = pre_evt && ((st_reg.pre_cnt & ps_mask) == ps_mask);
      end else begin
         inc = samp_en && ps_out && !st_reg.samp;
      end
   end

   // register port decode
   always_comb begin
      wr_low  = wr_in && (addr_in == tzc_pkg::OFS_CNT_LOW);
      wr_high = wr_in && (addr_in == tzc_pkg::OFS_CNT_HIGH);
      wr_int  = wr_in && (addr_in == tzc_pkg::OFS_INT_STAT);
      ovf_set = inc && (st_reg.cnt == tzc_pkg::CNT_ALL_ONE) &&
                !wr_low && !wr_high;
   end

   // next state
   always_comb begin
      st_next        = st_reg;
      st_next.pin_s1 = count_pin_in;
      st_next.pin_s2 = st_reg.pin_s1;
      st_next.pin_d  = st_reg.pin_s2;
      st_next.phase  = 2'(st_reg.phase + 2'h1);
      // prescaler and sampler
      if (pre_evt) begin
         st_next.pre_cnt = 8'(st_reg.pre_cnt + 8'h01);
      end
      if (samp_en) begin
         st_next.samp = ps_out;
      end
      // counter keeps running whatever the enable, writes win
      if (inc) begin
         st_next.cnt = 16'(st_reg.cnt + 16'h0001);
      end
      if (wr_low) begin
         st_next.cnt[7:0] = wdata_in;
      end
      if (wr_high) begin
         st_next.cnt[15:8] = wdata_in;
      end
      // control and enable writes
      if (wr_in && (addr_in == tzc_pkg::OFS_CONTROL)) begin
         st_next.int_edge = wdata_in[tzc_pkg::BIT_INT_EDGE];
         st_next.edge_sel = wdata_in[tzc_pkg::BIT_EDGE_SEL];
         st_next.src_sel  = wdata_in[tzc_pkg::BIT_SRC_SEL];
         st_next.ps       = wdata_in[tzc_pkg::PS_MSB:tzc_pkg::PS_LSB];
      end
      if (wr_int) begin
         st_next.ovf_en = wdata_in[tzc_pkg::BIT_OVF_EN];
      end
      if (wr_in && (addr_in == tzc_pkg::OFS_INT_MASK)) begin
         st_next.ovf_mask = wdata_in[tzc_pkg::BIT_OVF_FLAG];
      end
      // flag: clear by vector or write one, a wrap wins over both
      if (vector_ack_in ||
          (wr_int && wdata_in[tzc_pkg::BIT_OVF_FLAG])) begin
         st_next.ovf_flag = 1'b0;
      end
      if (ovf_set) begin
         st_next.ovf_flag = 1'b1;
      end
      st_next.irq = st_next.ovf_flag && st_next.ovf_en &&
                    st_next.ovf_mask;
      // read data valid only in the cycle after the strobe
      st_next.rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            tzc_pkg::OFS_CONTROL: begin
               st_next.rdata[tzc_pkg::BIT_INT_EDGE] = st_reg.int_edge;
               st_next.rdata[tzc_pkg::BIT_EDGE_SEL] = st_reg.edge_sel;
               st_next.rdata[tzc_pkg::BIT_SRC_SEL]  = st_reg.src_sel;
               st_next.rdata[tzc_pkg::PS_MSB:tzc_pkg::PS_LSB] = st_reg.ps;
            end
            tzc_pkg::OFS_INT_STAT: begin
               st_next.rdata[tzc_pkg::BIT_OVF_FLAG] = st_reg.ovf_flag;
               st_next.rdata[tzc_pkg::BIT_OVF_EN]   = st_reg.ovf_en;
            end
            tzc_pkg::OFS_CNT_LOW:  st_next.rdata = st_reg.cnt[7:0];
            tzc_pkg::OFS_CNT_HIGH: st_next.rdata = st_reg.cnt[15:8];
            tzc_pkg::OFS_INT_MASK: begin
               st_next.rdata[tzc_pkg::BIT_OVF_FLAG] = st_reg.ovf_mask;
            end
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         st_reg          <= '0;
         st_reg.cnt      <= tzc_pkg::RST_COUNT;
         st_reg.int_edge <= tzc_pkg::RST_CONTROL[tzc_pkg::BIT_INT_EDGE];
         st_reg.edge_sel <= tzc_pkg::RST_CONTROL[tzc_pkg::BIT_EDGE_SEL];
         st_reg.src_sel  <= tzc_pkg::RST_CONTROL[tzc_pkg::BIT_SRC_SEL];
         st_reg.ps       <=
            tzc_pkg::RST_CONTROL[tzc_pkg::PS_MSB:tzc_pkg::PS_LSB];
         st_reg.ovf_flag <= tzc_pkg::RST_INT[tzc_pkg::BIT_OVF_FLAG];
         st_reg.ovf_en   <= tzc_pkg::RST_INT[tzc_pkg::BIT_OVF_EN];
         st_reg.ovf_mask <= tzc_pkg::RST_MASK;
         // a high sample can never be taken for a rise after reset
         st_reg.samp     <= tzc_pkg::RST_SAMP;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign rdata_out = st_reg.rdata;
   assign irq_out   = st_reg.irq;

   // helper: no control write this or last cycle
   logic ctl_wr;
   logic ctl_wr_d;
   assign ctl_wr = wr_in && (addr_in == tzc_pkg::OFS_CONTROL);
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         ctl_wr_d <= 1'b0;
      end else begin
         ctl_wr_d <= ctl_wr;
      end
   end

   // internal mode only counts on instruction ticks
   property p_src_internal;
      @(posedge sys_clk_in) disable iff (srst_in)
      (st_reg.src_sel && inc) |-> tick_int;
   endproperty
   a_src_internal: assert property (p_src_internal)
      else $error("internal increment off the instruction tick");

   // pin mode counts a rise of the edge-selected prescaler output
   property p_ext_edge;
      @(posedge sys_clk_in) disable iff (srst_in)
      (!st_reg.src_sel && inc) |-> (ps_out && !st_reg.samp && samp_en);
   endproperty
   a_ext_edge: assert property (p_ext_edge)
      else $error("pin increment without selected transition");

   // internal 1:1 counts every instruction cycle
   property p_ratio_one;
      @(posedge sys_clk_in) disable iff (srst_in)
      (st_reg.src_sel && (st_reg.ps == 4'h0) && tick_int) |-> inc;
   endproperty
   a_ratio_one: assert property (p_ratio_one)
      else $error("1:1 prescale missed a tick");

   // increment moves counter by one, wrapping
   property p_count_up;
      @(posedge sys_clk_in) disable iff (srst_in)
      (inc && !wr_low && !wr_high) |=>
         (st_reg.cnt == 16'($past(st_reg.cnt) + 16'h0001));
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("counter did not advance by one");

   // wrap sets flag
   property p_ovf_set;
      @(posedge sys_clk_in) disable iff (srst_in)
      ovf_set |=> (st_reg.ovf_flag && (st_reg.cnt == 16'h0000));
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("wrap did not set overflow flag");

   // request follows flag, enable and mask
   property p_irq_gate;
      @(posedge sys_clk_in) disable iff (srst_in)
      ##1 (irq_out == (st_reg.ovf_flag && st_reg.ovf_en &&
                       st_reg.ovf_mask));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt output disagrees with flag and enable");

   // vector clears flag unless a wrap coincides
   property p_vec_clear;
      @(posedge sys_clk_in) disable iff (srst_in)
      (vector_ack_in && !ovf_set) |=> !st_reg.ovf_flag;
   endproperty
   a_vec_clear: assert property (p_vec_clear)
      else $error("vector did not clear overflow flag");

   // sampling only on the two sampling phases
   property p_samp_phase;
      @(posedge sys_clk_in) disable iff (srst_in)
      (!st_reg.src_sel && inc) |-> (st_reg.phase[0] == 1'b1);
   endproperty
   a_samp_phase: assert property (p_samp_phase)
      else $error("pin increment outside sampling phase");

   // synced pin edge at 1:1 gives an increment within one more cycle
   property p_delay;
      @(posedge sys_clk_in) disable iff (srst_in)
      (!st_reg.src_sel && (st_reg.ps == 4'h0) && !ctl_wr && !ctl_wr_d &&
       pin_eff && !pin_eff_d) |-> ##[0:1] inc;
   endproperty
   a_delay: assert property (p_delay)
      else $error("pin edge not counted in time");

   // high byte read returns the counter high byte
   property p_read_high;
      @(posedge sys_clk_in) disable iff (srst_in)
      (rd_in && (addr_in == tzc_pkg::OFS_CNT_HIGH)) |=>
         (rdata_out == $past(st_reg.cnt[15:8]));
   endproperty
   a_read_high: assert property (p_read_high)
      else $error("high byte read mismatch");

   // never two increments back to back
   property p_one_pulse;
      @(posedge sys_clk_in) disable iff (srst_in)
      inc |=> !inc;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("double increment");

   // main scenarios
   c_overflow: cover property (@(posedge sys_clk_in) disable iff (srst_in)
      ovf_set);
   c_irq: cover property (@(posedge sys_clk_in) disable iff (srst_in)
      $rose(irq_out));
   c_ext_inc: cover property (@(posedge sys_clk_in) disable iff (srst_in)
      (!st_reg.src_sel && inc));
   c_vec: cover property (@(posedge sys_clk_in) disable iff (srst_in)
      (vector_ack_in && st_reg.ovf_flag));
endmodule

// file: testbench/tzc_pin_source.sv
/*
 * behavioural source of the external count pin: on a go pulse it
 * makes a burst of whole pulses with a set half period.
 * assumes the bench pulses go_in only while busy_out is low.
 */
`timescale 1ns/100ps
module tzc_pin_source (
   input  wire logic       clk_in,   // system clock
   input  wire logic       rst_in,   // sync reset, active high
   input  wire logic       go_in,    // start a burst
   input  wire logic [7:0] n_in,     // pulses in the burst
   input  wire logic [7:0] half_in,  // half period, clock cycles
   output logic            pin_out,  // count pin, idle low
   output logic            busy_out  // burst in progress
);
   logic [8:0] togg_left;
   logic [7:0] tick;

   // pin stands low between bursts, toggles every half period inside
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_out   <= 1'b0;
         busy_out  <= 1'b0;
         togg_left <= 9'h000;
         tick      <= 8'h00;
      end else if (go_in && !busy_out) begin
         busy_out  <= 1'b1;
         togg_left <= {n_in, 1'b0};
         tick      <= 8'h00;
      end else if (busy_out) begin
         if (tick == half_in - 8'h01) begin
            tick <= 8'h00;
            if (togg_left == 9'h000) begin
               busy_out <= 1'b0;
            end else begin
               pin_out   <= ~pin_out;
               togg_left <= togg_left - 9'h001;
            end
         end else begin
            tick <= tick + 8'h01;
         end
      end
   end
endmodule

// file: testbench/timer0_counter_16bit_tb_top.sv
/*
 * self-checking bench of the timer zero counter: register table,
 * wrap and overflow interrupt, prescaler, pin edge counting, latency.
 * assumes tzc_timer and tzc_pin_source are compiled before this file.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module timer0_counter_16bit_tb_top;
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;
      logic [7:0] e;} tzc_row_s;
   logic sys_clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic count_pin_in, vector_ack_in = 1'b0, irq_out, go = 1'b0, busy;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, v, v2;
   logic [7:0] n = 8'h00;
   int err_count = 0, n_tests = 0, cyc = 0, p0, d, k, p;
   tzc_row_s rows [0:18] = '{'{0,8'h05,8'h00,8'h00},
      '{0,8'h07,8'h00,8'h00}, '{0,8'h0B,8'h00,8'h00},
      '{0,8'h0C,8'h00,8'h00}, '{0,8'h06,8'h00,8'h00},
      '{0,8'h0D,8'h00,8'h20}, '{0,8'h3F,8'h00,8'h00},
      '{1,8'h3F,8'hAA,8'h00}, '{0,8'h3F,8'h00,8'h00},
      '{1,8'h05,8'hFF,8'h00}, '{0,8'h05,8'h00,8'hFE},
      '{1,8'h05,8'h00,8'h00}, '{1,8'h0B,8'h12,8'h00},
      '{0,8'h0B,8'h00,8'h12}, '{1,8'h0C,8'h34,8'h00},
      '{0,8'h0C,8'h00,8'h34}, '{1,8'h0D,8'h00,8'h00},
      '{0,8'h0D,8'h00,8'h00}, '{1,8'h0D,8'h20,8'h00}};
   logic [31:0] pins [0:2] = '{32'h40050505, 32'h00030303, 32'h04080203};
   int codes [0:3] = '{0, 2, 8, 15};

   tzc_timer dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .count_pin_in(count_pin_in),
      .vector_ack_in(vector_ack_in), .rdata_out(rdata_out),
      .irq_out(irq_out));
   tzc_pin_source src (.clk_in(sys_clk_in), .rst_in(srst_in), .go_in(go),
      .n_in(n), .half_in(8'h04), .pin_out(count_pin_in),
      .busy_out(busy));

   // 100 MHz clock
   always #5 sys_clk_in = ~sys_clk_in;
   // hang guard
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      @(posedge sys_clk_in);
      wr_in <= 1'b1; addr_in <= a; wdata_in <= dt;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge sys_clk_in);
      rd_in <= 1'b1; addr_in <= a;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1 q = rdata_out;
   endtask
   task automatic burst(input logic [7:0] cnt);
      @(posedge sys_clk_in);
      go <= 1'b1; n <= cnt;
      @(posedge sys_clk_in);
      go <= 1'b0;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else begin rd(rows[i].a, v); `CHK(v, rows[i].e) end
      end
      // wrap from all ones, flag, enable gating, vector clear
      wr(8'h0B, 8'hFE); wr(8'h0C, 8'hFF); wr(8'h07, 8'h02);
      wr(8'h05, 8'h20);
      repeat (16) @(posedge sys_clk_in);
      #1 `CHK(irq_out, 1'b1)
      rd(8'h07, v); `CHK(v, 8'h22)
      rd(8'h0C, v); `CHK(v, 8'h00)
      wr(8'h07, 8'h00); rd(8'h0B, v);
      `CHK(irq_out, 1'b0)
      rd(8'h07, v2); `CHK(v2, 8'h20)
      rd(8'h0B, v2); `CHK(v2 != v, 1'b1)
      @(posedge sys_clk_in) vector_ack_in <= 1'b1;
      @(posedge sys_clk_in) vector_ack_in <= 1'b0;
      rd(8'h07, v); `CHK(v, 8'h00)
      // internal clock at prescale codes 0, 2, 8 and 15, four periods each
      foreach (codes[i]) begin
         p = 4 << ((codes[i] > 8) ? 8 : codes[i]);
         wr(8'h05, 8'h00); wr(8'h0B, 8'h00); wr(8'h0C, 8'h00);
         wr(8'h05, 8'h20 | 8'(codes[i] << 1));
         repeat (4 * p) @(posedge sys_clk_in);
         rd(8'h0B, v);
         `CHK((v >= 8'h04) && (v <= 8'h05), 1'b1)
      end
      // pin edges of either polarity, with and without prescale
      foreach (pins[i]) begin
         wr(8'h05, pins[i][31:24]);
         repeat (10) @(posedge sys_clk_in);
         wr(8'h0B, 8'h00); wr(8'h0C, 8'h00); burst(pins[i][23:16]);
         @(posedge sys_clk_in);
         for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge sys_clk_in);
         `CHK(busy, 1'b0)
         repeat (12) @(posedge sys_clk_in);
         rd(8'h0B, v);
         `CHK((v >= pins[i][15:8]) && (v <= pins[i][7:0]), 1'b1)
      end
      // one rising edge: latency and single increment
      wr(8'h05, 8'h40); wr(8'h0B, 8'h00); burst(8'h01);
      rd_in <= 1'b1; addr_in <= 8'h0B; p0 = -1; d = -1;
      for (k = 0; k < 24; k++) begin
         @(posedge sys_clk_in);
         #1 if (count_pin_in === 1'b1 && p0 < 0) p0 = k;
         if (rdata_out === 8'h01 && d < 0) d = k;
      end
      @(posedge sys_clk_in) rd_in <= 1'b0;
      `CHK((d - p0 - 1 >= 3) && (d - p0 - 1 <= 7) && p0 >= 0, 1'b1)
      rd(8'h0B, v); `CHK(v, 8'h01)
      // wrap, clear by writing one, then a mid-run reset
      wr(8'h07, 8'h02); wr(8'h0B, 8'hFF); wr(8'h0C, 8'hFF);
      wr(8'h05, 8'h20); repeat (8) @(posedge sys_clk_in);
      #1 `CHK(irq_out, 1'b1)
      wr(8'h07, 8'h22); rd(8'h07, v); `CHK(v, 8'h02)
      `CHK(irq_out, 1'b0)
      wr(8'h0D, 8'h00);
      @(posedge sys_clk_in) srst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      for (k = 0; k < 6; k++) begin
         rd(rows[k].a, v); `CHK(v, rows[k].e)
      end
      `CHK(irq_out, 1'b0)
      report_and_stop();
   end
endmodule
